// ==== rtl/ihk_top.sv ====
/*
  housekeeping around one i2c host controller: reset control, power gate
  line freeze, latency reporting, interrupt status and mask, bus error
  detection and sda hold adjustment, all behind an apb slave.
  assumes the protocol engine and dma sit outside on pclk; pins are
  open-drain with external pull-ups and are synchronised here.
*/
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Operation
// - each controller has its own reset, controlled by a software register
// - controller and dma stay in reset until software releases them
// - while power gated, scl and sda hold the drive they had when gating began, with no transitions
// - bus stays undisturbed for peripherals during the gated period
// - latency requirement reported to power manager through registers
// - latency scheme selectable: hardware derived or driver set
// - one interrupt output signals that service is needed
// - separate host, dma and tx completion status registers
// - interrupts cleared only by software writes to status registers
// - interrupt output active high, level, held while cause pends
// - bus line errors detected and shown in memory-mapped status
// - software sets sda hold time after falling scl at run time
module ihk_top import ihk_pkg::*; #(
  parameter int STUCK_LIMIT = STUCK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic eng_scl_oe,
  input wire logic eng_sda_oe,
  input wire logic eng_busy,
  input wire logic eng_svc,
  input wire logic dma_evt,
  input wire logic txc_evt,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  output logic hc_rst_n,
  output logic dma_rst_n,
  output logic [15:0] ltr_value,
  output logic irq
);
  // pin synchronisers
  logic [1:0] scl_sync_ff, sda_sync_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
    end
  end
  logic scl_s, sda_s;
  assign scl_s = scl_sync_ff[1];
  assign sda_s = sda_sync_ff[1];

  // apb decode; zero-wait answer
  logic wr_en, rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, OFS_RESET) | hit(a, OFS_PWR) | hit(a, OFS_LTR_CTL) |
      hit(a, OFS_LTR_OUT) | hit(a, OFS_HC_STS) | hit(a, OFS_DMA_STS) |
      hit(a, OFS_TXC_STS) | hit(a, OFS_IRQ_MASK) | hit(a, OFS_HOLD) |
      hit(a, OFS_BUS_STAT);
  endfunction

  // control registers
  logic [1:0] rst_ff, nxt_rst;
  logic gate_ff, nxt_gate;
  logic ltr_sel_ff, nxt_ltr_sel;
  logic [15:0] ltr_sw_ff, nxt_ltr_sw;
  logic [15:0] hold_ff, nxt_hold;
  logic [IRQ_SRC_W-1:0] mask_ff, nxt_mask;

  // software writes to control registers
  always_comb begin
    nxt_rst = rst_ff;
    nxt_gate = gate_ff;
    nxt_ltr_sel = ltr_sel_ff;
    nxt_ltr_sw = ltr_sw_ff;
    nxt_hold = hold_ff;
    nxt_mask = mask_ff;
    if (wr_en) begin
      if (hit(paddr, OFS_RESET)) begin
        nxt_rst = {pwdata[RST_DMA_BIT], pwdata[RST_HC_BIT]};
      end
      if (hit(paddr, OFS_PWR)) begin
        nxt_gate = pwdata[0];
      end
      if (hit(paddr, OFS_LTR_CTL)) begin
        nxt_ltr_sel = pwdata[LTR_SEL_BIT];
        nxt_ltr_sw = pwdata[LTR_W-1:0];
      end
      if (hit(paddr, OFS_HOLD)) begin
        nxt_hold = pwdata[15:0];
      end
      if (hit(paddr, OFS_IRQ_MASK)) begin
        nxt_mask = pwdata[IRQ_SRC_W-1:0];
      end
    end
  end

  // control state; reset bits zero keeps both blocks in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_ff <= 2'h0;
      gate_ff <= 1'b0;
      ltr_sel_ff <= 1'b0;
      ltr_sw_ff <= 16'h0000;
      hold_ff <= HOLD_RST;
      mask_ff <= '0;
    end else begin
      rst_ff <= nxt_rst;
      gate_ff <= nxt_gate;
      ltr_sel_ff <= nxt_ltr_sel;
      ltr_sw_ff <= nxt_ltr_sw;
      hold_ff <= nxt_hold;
      mask_ff <= nxt_mask;
    end
  end

  // sda hold stage on the engine's output
  logic eng_scl_d_ff, nxt_eng_scl_d;
  logic sda_held;
  assign nxt_eng_scl_d = eng_scl_oe;
  ihk_hold #(.W(16)) u_hold (
    .pclk(pclk),
    .presetn(presetn),
    .hold_cyc(hold_ff),
    .scl_fall(eng_scl_oe & ~eng_scl_d_ff), // oe rising = scl falling
    .sda_in(eng_sda_oe),
    .sda_out(sda_held)
  );

  // bus error detection: sda low while released, scl stuck low
  logic [31:0] stuck_ff, nxt_stuck;
  logic arb_evt, stuck_evt;
  logic scl_oe_ff, sda_oe_ff, irq_ff;
  always_comb begin
    nxt_stuck = stuck_ff;
    if (scl_s || gate_ff || !rst_ff[0]) begin
      nxt_stuck = '0;
    end else if (stuck_ff != 32'(STUCK_LIMIT)) begin
      nxt_stuck = stuck_ff + 32'h1;
    end
  end
  assign stuck_evt = (stuck_ff == 32'(STUCK_LIMIT) - 32'h1);
  assign arb_evt = rst_ff[0] & ~gate_ff & eng_busy & scl_s & ~sda_s &
    ~sda_oe_ff;

  // status registers: set wins over write-one clear
  logic [2:0] hc_sts_ff, nxt_hc_sts;
  logic dma_sts_ff, nxt_dma_sts;
  logic txc_sts_ff, nxt_txc_sts;
  logic [2:0] hc_set;
  assign hc_set = {eng_svc & rst_ff[0], stuck_evt, arb_evt};
  always_comb begin
    nxt_hc_sts = hc_sts_ff;
    nxt_dma_sts = dma_sts_ff;
    nxt_txc_sts = txc_sts_ff;
    if (wr_en && hit(paddr, OFS_HC_STS)) begin
      nxt_hc_sts = hc_sts_ff & ~pwdata[2:0];
    end
    if (wr_en && hit(paddr, OFS_DMA_STS)) begin
      nxt_dma_sts = dma_sts_ff & ~pwdata[0];
    end
    if (wr_en && hit(paddr, OFS_TXC_STS)) begin
      nxt_txc_sts = txc_sts_ff & ~pwdata[0];
    end
    nxt_hc_sts = nxt_hc_sts | hc_set;
    nxt_dma_sts = nxt_dma_sts | (dma_evt & rst_ff[1]);
    nxt_txc_sts = nxt_txc_sts | (txc_evt & rst_ff[0]);
  end

  // output drive, irq and ltr
  logic nxt_scl_oe, nxt_sda_oe, nxt_irq;
  logic [15:0] ltr_ff, nxt_ltr;
  logic [IRQ_SRC_W-1:0] pend;
  assign pend = {txc_sts_ff, dma_sts_ff, hc_sts_ff};
  always_comb begin
    // frozen while gated so peripherals see no edge
    if (gate_ff) begin
      nxt_scl_oe = scl_oe_ff;
      nxt_sda_oe = sda_oe_ff;
    end else begin
      nxt_scl_oe = eng_scl_oe & rst_ff[0];
      nxt_sda_oe = sda_held & rst_ff[0];
    end
    nxt_irq = |(pend & mask_ff);
    nxt_ltr = ltr_sel_ff ? ltr_sw_ff :
      ((eng_busy & rst_ff[0]) ? LTR_ACTIVE : LTR_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_scl_d_ff <= 1'b0;
      stuck_ff <= '0;
      hc_sts_ff <= '0;
      dma_sts_ff <= 1'b0;
      txc_sts_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
      ltr_ff <= LTR_IDLE;
    end else begin
      eng_scl_d_ff <= nxt_eng_scl_d;
      stuck_ff <= nxt_stuck;
      hc_sts_ff <= nxt_hc_sts;
      dma_sts_ff <= nxt_dma_sts;
      txc_sts_ff <= nxt_txc_sts;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
      irq_ff <= nxt_irq;
      ltr_ff <= nxt_ltr;
    end
  end

  // apb read mux, registered on the setup cycle
  logic [31:0] rdata_ff, nxt_rdata;
  logic err_ff, nxt_err;
  always_comb begin
    nxt_rdata = 32'h0;
    nxt_err = 1'b0;
    if (psel && !penable) begin
      nxt_err = ~mapped(paddr);
      case (paddr)
        OFS_RESET: nxt_rdata = {30'h0, rst_ff};
        OFS_PWR: nxt_rdata = {31'h0, gate_ff};
        OFS_LTR_CTL: nxt_rdata = {15'h0, ltr_sel_ff, ltr_sw_ff};
        OFS_LTR_OUT: nxt_rdata = {16'h0, ltr_ff};
        OFS_HC_STS: nxt_rdata = {29'h0, hc_sts_ff};
        OFS_DMA_STS: nxt_rdata = {31'h0, dma_sts_ff};
        OFS_TXC_STS: nxt_rdata = {31'h0, txc_sts_ff};
        OFS_IRQ_MASK: nxt_rdata = {27'h0, mask_ff};
        OFS_HOLD: nxt_rdata = {16'h0, hold_ff};
        OFS_BUS_STAT: nxt_rdata = {29'h0, eng_busy, sda_s, scl_s};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff <= 32'h0;
      err_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      err_ff <= nxt_err;
    end
  end

  assign prdata = rdata_ff;
  assign pslverr = err_ff;
  assign pready = 1'b1;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_oe_ff;
  assign sda_oe = sda_oe_ff;
  assign hc_rst_n = rst_ff[0];
  assign dma_rst_n = rst_ff[1];
  assign ltr_value = ltr_ff;
  assign irq = irq_ff;

  // assertions
  a_gate_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    gate_ff && $past(gate_ff) |-> $stable(scl_oe) && $stable(sda_oe))
    else $error("bus lines moved while gated");
  a_gate_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    gate_ff && !(wr_en && paddr == OFS_PWR) |=> gate_ff)
    else $error("gate left without software write");
  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(pend & mask_ff)) |=> irq)
    else $error("irq not raised for pending source");
  a_irq_or: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(|(pend & mask_ff)) |=> !irq)
    else $error("irq with nothing pending");
  a_dma_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    dma_sts_ff && !(wr_en && paddr == OFS_DMA_STS) |=> dma_sts_ff)
    else $error("dma status cleared without write");
  a_txc_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    txc_evt && rst_ff[0] |=> txc_sts_ff)
    else $error("tx completion not captured");
  a_rst_release: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_RESET |=> hc_rst_n == $past(pwdata[0]))
    else $error("reset register not applied");
  a_rst_held: assert property (
    @(posedge pclk) disable iff (!presetn)
    !hc_rst_n && !(wr_en && paddr == OFS_RESET) |=> !hc_rst_n)
    else $error("controller left reset without write");
  a_ltr_sw: assert property (
    @(posedge pclk) disable iff (!presetn)
    ltr_sel_ff && $stable(ltr_sw_ff) |=> ltr_value == $past(ltr_sw_ff))
    else $error("driver latency value not reported");
  a_ltr_hw: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ltr_sel_ff && !eng_busy |=> ltr_value == LTR_IDLE)
    else $error("idle latency wrong");
  a_stuck_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    stuck_evt |=> hc_sts_ff[HC_STUCK_BIT])
    else $error("stuck clock not flagged");
  a_hold_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && paddr == OFS_HOLD |=> hold_ff == $past(pwdata[15:0]))
    else $error("hold time not written");
endmodule // ihk_top

// ==== rtl/ihk_pkg.sv ====
/*
  package for the i2c host housekeeping block: register offsets, field
  positions, reset values and timing constants.
  assumes a 32-bit apb slave with word-aligned registers.
*/
package ihk_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_RESET = 8'h00;   // controller/dma reset control
  localparam logic [7:0] OFS_PWR = 8'h04;     // power gate control
  localparam logic [7:0] OFS_LTR_CTL = 8'h08; // latency scheme + sw value
  localparam logic [7:0] OFS_LTR_OUT = 8'h0c; // reported latency (ro)
  localparam logic [7:0] OFS_HC_STS = 8'h10;  // host controller irq status
  localparam logic [7:0] OFS_DMA_STS = 8'h14; // dma irq status
  localparam logic [7:0] OFS_TXC_STS = 8'h18; // tx completion irq status
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c; // enable mask, same layout
  localparam logic [7:0] OFS_HOLD = 8'h20;    // sda hold time in cycles
  localparam logic [7:0] OFS_BUS_STAT = 8'h24; // live bus state (ro)

  // reset register fields
  localparam int RST_HC_BIT = 0;
  localparam int RST_DMA_BIT = 1;
  // host controller status fields
  localparam int HC_ARB_BIT = 0;    // sda low while released
  localparam int HC_STUCK_BIT = 1;  // scl stuck low
  localparam int HC_SVC_BIT = 2;    // engine service request
  // combined mask layout
  localparam int MSK_HC_LSB = 0;
  localparam int MSK_DMA_BIT = 3;
  localparam int MSK_TXC_BIT = 4;
  localparam int IRQ_SRC_W = 5;
  // ltr control fields
  localparam int LTR_SEL_BIT = 16;
  localparam int LTR_W = 16;

  localparam logic [15:0] HOLD_RST = 16'h0001;
  localparam logic [15:0] LTR_ACTIVE = 16'h0000;  // busy: no latency allowed
  localparam logic [15:0] LTR_IDLE = 16'hffff;    // idle: any latency

  // stuck clock detection: 100 us at 125 MHz
  localparam int STUCK_US = 100;
  localparam int CLK_MHZ = 125;
  localparam int STUCK_CYC = STUCK_US * CLK_MHZ;
endpackage

// ==== rtl/ihk_hold.sv ====
/*
  sda hold timer: after each falling scl edge of the engine, the engine's
  sda value is held back for a programmed number of cycles.
  assumes engine scl/sda are on pclk.
*/
`timescale 1ns/1ps
module ihk_hold import ihk_pkg::*; #(
  parameter int W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] hold_cyc,
  input wire logic scl_fall,
  input wire logic sda_in,
  output logic sda_out
);
  logic [W-1:0] cnt_ff, nxt_cnt;
  logic sda_ff, nxt_sda;

  // count down after each fall, then follow the engine sda
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_sda = sda_ff;
    if (scl_fall) begin
      nxt_cnt = hold_cyc;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end else begin
      nxt_sda = sda_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      sda_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      sda_ff <= nxt_sda;
    end
  end

  assign sda_out = sda_ff;
endmodule // ihk_hold

// ==== tb/ihk_bus_model.sv ====
/*
  serial bus wires with pull-ups and one peripheral that may hold either
  line low. assumes open-drain pads: every party only ever pulls low.
*/
`timescale 1ns/1ps
module ihk_bus_model (
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic per_scl_low,
  input wire logic per_sda_low,
  output logic scl_line,
  output logic sda_line
);
  // wired-and of all pull-downs, pull-up wins when released
  assign scl_line = !(scl_oe || per_scl_low);
  assign sda_line = !(sda_oe || per_sda_low);
endmodule // ihk_bus_model

// ==== tb/i2c_host_reset_power_irq_tb_top.sv ====
/*
  self-checking bench for ihk_top: reset, then apb register rows, latency,
  power gate, hold, bus error and interrupt cases.
  assumes zero-wait apb and a short stuck-clock limit.
*/
`timescale 1ns/1ps
module i2c_host_reset_power_irq_tb_top import ihk_pkg::*; ();
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic eng_scl_oe, eng_sda_oe, eng_busy, eng_svc, dma_evt, txc_evt;
  logic scl_line, sda_line, per_scl_low, per_sda_low;
  logic scl_oe, sda_oe, hc_rst_n, dma_rst_n, irq, scl_out, sda_out;
  logic [15:0] ltr_value;
  logic [72:0] rows [0:4];
  int n_errors, checked;

  ihk_top #(.STUCK_LIMIT(20)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .eng_scl_oe(eng_scl_oe), .eng_sda_oe(eng_sda_oe), .eng_busy(eng_busy),
    .eng_svc(eng_svc), .dma_evt(dma_evt), .txc_evt(txc_evt),
    .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe),
    .hc_rst_n(hc_rst_n),
    .dma_rst_n(dma_rst_n), .ltr_value(ltr_value), .irq(irq));

  ihk_bus_model bus (.scl_oe(scl_oe), .sda_oe(sda_oe),
    .per_scl_low(per_scl_low), .per_sda_low(per_sda_low),
    .scl_line(scl_line), .sda_line(sda_line));

  // clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // verdict and end of run
  task report_and_stop;
    $display("checked %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // one apb transfer; read data and error land in rd and er
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    if (n >= 100) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {eng_scl_oe, eng_sda_oe, eng_busy, eng_svc, dma_evt, txc_evt} = '0;
    {per_scl_low, per_sda_low, presetn} = '0;
    rows = '{{OFS_HOLD, 32'h7, 32'h7, 1'b0},
      {OFS_IRQ_MASK, 32'h1f, 32'h1f, 1'b0},
      {OFS_LTR_CTL, 32'h1a5c3, 32'h1a5c3, 1'b0},
      {8'h40, 32'h5, 32'h0, 1'b1},
      {OFS_RESET, 32'h3, 32'h3, 1'b0}};
    cyc(4);
    chk({hc_rst_n, dma_rst_n, irq, scl_oe, sda_oe, scl_out, sda_out}, 0);
    chk(pready, 1);
    chk(ltr_value, LTR_IDLE);
    presetn <= 1'b1;
    apb(0, OFS_HOLD, 0);
    chk(rd, HOLD_RST);
    apb(1, OFS_RESET, 1);
    cyc(2);
    chk({hc_rst_n, dma_rst_n}, 2'b10);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, rows[i][72:65], rows[i][64:33]);
      apb(0, rows[i][72:65], 0);
      chk(rd, rows[i][32:1]);
      chk(er, rows[i][0]);
    end
    cyc(2);
    chk(ltr_value, 16'ha5c3);
    chk({hc_rst_n, dma_rst_n}, 2'b11);
    $display("register rows done");
    apb(1, OFS_LTR_CTL, 0);
    eng_busy <= 1'b1;
    cyc(3);
    chk(ltr_value, LTR_ACTIVE);
    apb(0, OFS_LTR_OUT, 0);
    chk(rd, {16'h0, LTR_ACTIVE});
    eng_busy <= 1'b0;
    cyc(3);
    chk(ltr_value, LTR_IDLE);
    $display("latency test done");
    apb(1, OFS_PWR, 1);
    eng_scl_oe <= 1'b1;
    eng_sda_oe <= 1'b1;
    repeat (6) begin
      @(posedge pclk);
      chk({scl_oe, sda_oe, scl_line, sda_line}, 4'b0011);
    end
    apb(1, OFS_PWR, 0);
    cyc(3);
    chk(scl_oe, 1);
    eng_scl_oe <= 1'b0;
    eng_sda_oe <= 1'b0;
    cyc(20);
    $display("power gate test done");
    eng_scl_oe <= 1'b1;
    eng_sda_oe <= 1'b1;
    cyc(3);
    chk(sda_oe, 0);
    cyc(12);
    chk(sda_oe, 1);
    eng_scl_oe <= 1'b0;
    eng_sda_oe <= 1'b0;
    cyc(20);
    $display("hold test done");
    apb(1, OFS_HC_STS, 7);
    eng_busy <= 1'b1;
    per_sda_low <= 1'b1;
    cyc(4);
    per_scl_low <= 1'b1;
    cyc(30);
    apb(0, OFS_HC_STS, 0);
    chk(rd & 32'h3, 32'h3);
    {eng_busy, per_scl_low, per_sda_low} <= 3'b000;
    cyc(3);
    chk(irq, 1);
    apb(1, OFS_HC_STS, 7);
    apb(1, OFS_DMA_STS, 1);
    apb(1, OFS_TXC_STS, 1);
    cyc(2);
    chk(irq, 0);
    $display("bus error test done");
    @(posedge pclk) eng_svc <= 1'b1;
    @(posedge pclk) eng_svc <= 1'b0;
    dma_evt <= 1'b1;
    @(posedge pclk) dma_evt <= 1'b0;
    cyc(3);
    chk(irq, 1);
    apb(0, OFS_HC_STS, 0);
    chk(rd, 32'h1 << HC_SVC_BIT);
    apb(0, OFS_DMA_STS, 0);
    chk(rd, 1);
    apb(1, OFS_HC_STS, 32'h1 << HC_SVC_BIT);
    cyc(2);
    chk(irq, 1);
    apb(1, OFS_DMA_STS, 1);
    cyc(2);
    chk(irq, 0);
    apb(1, OFS_IRQ_MASK, 0);
    @(posedge pclk) txc_evt <= 1'b1;
    @(posedge pclk) txc_evt <= 1'b0;
    cyc(3);
    chk(irq, 0);
    apb(0, OFS_TXC_STS, 0);
    chk(rd, 1);
    apb(1, OFS_IRQ_MASK, 32'h1 << MSK_TXC_BIT);
    cyc(2);
    chk(irq, 1);
    apb(1, OFS_TXC_STS, 1);
    cyc(2);
    chk(irq, 0);
    $display("interrupt test done");
    apb(0, OFS_BUS_STAT, 0);
    chk(rd, 32'h3);
    apb(1, OFS_RESET, 0);
    cyc(2);
    chk({hc_rst_n, dma_rst_n}, 2'b00);
    $display("reset reassert test done");
    apb(1, OFS_LTR_CTL, 32'h10001);
    cyc(2);
    chk(ltr_value, 16'h0001);
    presetn <= 1'b0;
    cyc(2);
    chk({hc_rst_n, dma_rst_n, irq, scl_oe, sda_oe}, 0);
    chk(ltr_value, LTR_IDLE);
    presetn <= 1'b1;
    apb(0, OFS_HOLD, 0);
    chk(rd, HOLD_RST);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule // i2c_host_reset_power_irq_tb_top
